// ### tme_trigger_ctrl.sv
`timescale 1ns/1ps
module tme_trigger_ctrl
#(
    parameter logic [11:0] OFS_BRIGHT = tme_pkg::OFS_BRIGHT_DEF,
    parameter logic [11:0] OFS_SHUTTER = tme_pkg::OFS_SHUTTER_DEF,
    parameter logic [11:0] BRIGHT_MIN = tme_pkg::BRIGHT_MIN_DEF,
    parameter logic [11:0] BRIGHT_MAX = tme_pkg::BRIGHT_MAX_DEF
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register access
    input wire logic [tme_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Pixel depth
    input wire logic pixel_16bit,
    // Trigger settings
    output logic trig_polarity,
    output logic [tme_pkg::ORIGIN_W-1:0] trig_origin,
    output logic [tme_pkg::STYLE_W-1:0] trig_style
);
    import tme_pkg::*;

    // ***************************************************
    // Helpers
    // ***************************************************
    function automatic logic trig_bad(input logic [2:0] org, input logic [3:0] sty);
        logic org_ok;
        logic sty_ok;
        org_ok = (org <= ORIGIN_PORT_MAX) || (org == ORIGIN_SOFTWARE);
        sty_ok = (sty == STYLE_PROG) || (sty == STYLE_LEVEL);
        return !org_ok || !sty_ok || (org == ORIGIN_SOFTWARE && sty == STYLE_LEVEL);
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    logic wr_en;
    logic rd_en;
    logic [ORIGIN_W-1:0] w_origin;
    logic [STYLE_W-1:0] w_style;
    logic [VALUE_W-1:0] w_value;
    logic err_trig_reg;
    logic [2:0] feat_wr;
    logic [2:0] feat_flag;
    logic [2:0][VALUE_W-1:0] feat_lo;
    logic [2:0][VALUE_W-1:0] feat_hi;
    logic [31:0] trig_word;
    logic [31:0] err_word;
    logic [31:0] rdata_next;

    assign wr_en = ce && reg_wr;
    assign rd_en = ce && reg_rd;
    assign w_origin = reg_wdata[POS_ORIGIN_LO +: ORIGIN_W];
    assign w_style = reg_wdata[POS_STYLE_LO +: STYLE_W];
    assign w_value = reg_wdata[VALUE_W-1:0];

    // ***************************************************
    // Trigger control register
    // ***************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trig_polarity <= RST_POLARITY;
            trig_origin <= RST_ORIGIN;
            trig_style <= RST_STYLE;
        end
        else if (wr_en && hit(reg_addr, OFS_TRIG_CTRL))
        begin
            trig_polarity <= reg_wdata[POS_POLARITY];
            trig_origin <= w_origin;
            trig_style <= w_style;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            err_trig_reg <= 1'b0;
        else if (wr_en && hit(reg_addr, OFS_TRIG_CTRL))
            err_trig_reg <= trig_bad(w_origin, w_style);
    end

    // ***************************************************
    // Feature range flags: brightness, shutter, gain
    // ***************************************************
    assign feat_wr[0] = wr_en && hit(reg_addr, OFS_BRIGHT);
    assign feat_wr[1] = wr_en && hit(reg_addr, OFS_SHUTTER);
    assign feat_wr[2] = wr_en && hit(reg_addr, OFS_GAIN);
    assign feat_lo[0] = BRIGHT_MIN;
    assign feat_hi[0] = BRIGHT_MAX;
    assign feat_lo[1] = SHUTTER_MIN;
    assign feat_hi[1] = SHUTTER_MAX;
    assign feat_lo[2] = GAIN_MIN;
    assign feat_hi[2] = pixel_16bit ? GAIN_MAX_16BIT : GAIN_MAX_8BIT;

    for (genvar i = 0; i < 3; i++)
    begin : g_feat
        tme_range_flag #(.W(VALUE_W)) u_flag (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .update(feat_wr[i]),
            .value(w_value),
            .lo(feat_lo[i]),
            .hi(feat_hi[i]),
            .flag_reg(feat_flag[i])
        );
    end

    // ***************************************************
    // Read path
    // ***************************************************
    always_comb
    begin
        trig_word = 32'h0000_0000;
        trig_word[POS_PRESENT] = 1'b1;
        trig_word[POS_ABS_SEL] = 1'b0;
        trig_word[POS_ENABLE] = 1'b1;
        trig_word[POS_POLARITY] = trig_polarity;
        trig_word[POS_ORIGIN_LO +: ORIGIN_W] = trig_origin;
        trig_word[POS_STYLE_LO +: STYLE_W] = trig_style;
        err_word = 32'h0000_0000;
        err_word[POS_ERR_BRIGHT] = feat_flag[0];
        err_word[POS_ERR_SHUTTER] = feat_flag[1];
        err_word[POS_ERR_GAIN] = feat_flag[2];
        err_word[POS_ERR_TRIG] = err_trig_reg;
        if (hit(reg_addr, OFS_TRIG_CTRL))
            rdata_next = trig_word;
        else if (hit(reg_addr, OFS_ERR_HIGH))
            rdata_next = err_word;
        else
            rdata_next = 32'h0000_0000;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (rd_en)
            reg_rdata <= rdata_next;
    end

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence trig_read_s;
        rd_en && hit(reg_addr, OFS_TRIG_CTRL);
    endsequence

    sequence err_read_s;
        rd_en && hit(reg_addr, OFS_ERR_HIGH);
    endsequence

    presence_bit_a: assert property (trig_read_s |=> reg_rdata[POS_PRESENT])
        else $error("presence bit not read as 1");
    abs_select_a: assert property (trig_read_s |=> !reg_rdata[POS_ABS_SEL])
        else $error("absolute select not read as 0");
    enable_bit_a: assert property (trig_read_s |=> reg_rdata[POS_ENABLE])
        else $error("enable bit not read as 1");
    polarity_write_a: assert property (
        wr_en && hit(reg_addr, OFS_TRIG_CTRL) |=> trig_polarity == $past(reg_wdata[24]))
        else $error("polarity not taken from write");
    origin_readback_a: assert property (
        trig_read_s |=> reg_rdata[23:21] == $past(trig_origin))
        else $error("origin readback mismatch");
    style_keep_a: assert property (
        wr_en && hit(reg_addr, OFS_TRIG_CTRL) |=> trig_style == $past(w_style))
        else $error("style not taken from write");
    style_hold_a: assert property (
        !(wr_en && hit(reg_addr, OFS_TRIG_CTRL)) |=> $stable(trig_style))
        else $error("style changed without a trigger write");
    soft_level_a: assert property (
        wr_en && hit(reg_addr, OFS_TRIG_CTRL) && w_origin == 3'h7 && w_style == 4'h1
        |=> err_trig_reg ##0 trig_style == 4'h1)
        else $error("software level style not flagged or not kept");
    shutter_zero_a: assert property (
        feat_wr[1] |=> feat_flag[1] == ($past(w_value) == 12'h000))
        else $error("shutter flag wrong");
    gain_limit_a: assert property (
        feat_wr[2] |=> feat_flag[2] == ($past(pixel_16bit) ? ($past(w_value) > 12'h07D)
                                                          : ($past(w_value) > 12'h2E4)))
        else $error("gain flag wrong");
    err_readback_a: assert property (
        err_read_s |=> reg_rdata[23] == $past(feat_flag[2]) && reg_rdata[22:20] == 3'h0)
        else $error("error word readback wrong");

    soft_trig_c: cover property (wr_en && hit(reg_addr, OFS_TRIG_CTRL) && w_origin == 3'h7);
    shutter_err_c: cover property (feat_wr[1] ##1 feat_flag[1]);
    gain_clear_c: cover property (feat_flag[2] ##1 feat_wr[2] ##1 !feat_flag[2]);
    err_read_c: cover property (err_read_s ##1 reg_rdata[POS_ERR_TRIG]);
endmodule

// ### tme_pkg.sv
// Functional notes
// - Trigger control presence flag always reads 1 and is read-only.
// - Trigger control absolute-setting select always reads 0 and is read-only.
// - Trigger control enable always reads 1 and is read-only.
// - Trigger active level: 0 active low, 1 active high; resets to 1.
// - Trigger origin: codes 0 to 3 input ports, 7 software; resets to 0.
// - Trigger style: 0 programmable, 1 level; resets to 1.
// - Software origin permits programmable style only; level style is invalid there.
// - Each error status bit flags one feature control register, 1 meaning error.
// - Error flag is updated on every write to its feature register.
// - Flag set when setting is below minimum or above maximum.
// - Out-of-range settings never stop capture; the setting stays in use.
// - Error bit 0 flags an out-of-range brightness setting.
// - Error bit 7 flags an out-of-range shutter setting.
// - Error bit 8 flags an out-of-range gain setting.
// - Error bit 12 flags an out-of-range trigger control setting.
// - Shutter allowed range is 1 to 4095.
// - Gain allowed range is 0 to 740 at 8 bit, 0 to 125 at 16 bit.
// - Bit 0 of every register is the most significant of 32 bits.
package tme_pkg;
    // ***************************************************
    // Register offsets
    // ***************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_ERR_HIGH = 12'h640;
    localparam logic [11:0] OFS_TRIG_CTRL = 12'h830;
    localparam logic [11:0] OFS_BRIGHT_DEF = 12'h800;
    localparam logic [11:0] OFS_SHUTTER_DEF = 12'h81C;
    localparam logic [11:0] OFS_GAIN = 12'h820;

    // ***************************************************
    // Field positions, LSB index = 31 - documented bit
    // ***************************************************
    localparam int POS_PRESENT = 31;
    localparam int POS_ABS_SEL = 30;
    localparam int POS_ENABLE = 25;
    localparam int POS_POLARITY = 24;
    localparam int POS_ORIGIN_LO = 21;
    localparam int ORIGIN_W = 3;
    localparam int POS_STYLE_LO = 16;
    localparam int STYLE_W = 4;
    localparam int VALUE_W = 12;
    localparam int POS_ERR_BRIGHT = 31;
    localparam int POS_ERR_SHUTTER = 24;
    localparam int POS_ERR_GAIN = 23;
    localparam int POS_ERR_TRIG = 19;

    // ***************************************************
    // Codes and reset values
    // ***************************************************
    localparam logic [2:0] ORIGIN_PORT_MAX = 3'h3;
    localparam logic [2:0] ORIGIN_SOFTWARE = 3'h7;
    localparam logic [3:0] STYLE_PROG = 4'h0;
    localparam logic [3:0] STYLE_LEVEL = 4'h1;
    localparam logic RST_POLARITY = 1'b1;
    localparam logic [2:0] RST_ORIGIN = 3'h0;
    localparam logic [3:0] RST_STYLE = 4'h1;

    // ***************************************************
    // Limits
    // ***************************************************
    localparam logic [11:0] SHUTTER_MIN = 12'h001;
    localparam logic [11:0] SHUTTER_MAX = 12'hFFF;
    localparam logic [11:0] GAIN_MIN = 12'h000;
    localparam logic [11:0] GAIN_MAX_8BIT = 12'h2E4;
    localparam logic [11:0] GAIN_MAX_16BIT = 12'h07D;
    localparam logic [11:0] BRIGHT_MIN_DEF = 12'h000;
    localparam logic [11:0] BRIGHT_MAX_DEF = 12'h3FF;
endpackage

// ### tme_range_flag.sv
`timescale 1ns/1ps
module tme_range_flag
#(
    parameter int W = 12
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Update request
    input wire logic update,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    // Flag
    output logic flag_reg
);
    // ***************************************************
    // Range flag, rewritten on every update
    // ***************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_reg <= 1'b0;
        else if (ce && update)
            flag_reg <= (value < lo) || (value > hi);
    end

    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(ce && update) |=> $stable(flag_reg))
        else $error("range flag changed without an update");
endmodule

// ### tme_host.sv
`timescale 1ns/1ps
module tme_host
(
    // Clock
    clk,
    // Register port
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata
);
    input wire logic clk;
    output logic [11:0] reg_addr;
    output logic reg_wr;
    output logic reg_rd;
    output logic [31:0] reg_wdata;
    input wire logic [31:0] reg_rdata;

    // ***************************************
    // Host accesses, one strobe cycle each
    // ***************************************
    initial
    begin
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
        if (a == 12'h830)
            d = d & 32'hFFEF_F000;
        if (a == 12'h640)
            d = d & 32'h818F_FFFF;
    endtask
endmodule

// ### tme_trigger_ctrl_tb_top.sv
`timescale 1ns/1ps
module tme_trigger_ctrl_tb_top;
    import tme_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pixel_16bit = 1'b0;
    logic [11:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic trig_polarity;
    logic [2:0] trig_origin;
    logic [3:0] trig_style;
    logic [31:0] rv;
    logic pol;
    logic err;
    int error_cnt = 0;
    int checks_done = 0;

    always #12.5 clk = ~clk;

    tme_trigger_ctrl u_tme_trigger_ctrl (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pixel_16bit(pixel_16bit), .trig_polarity(trig_polarity),
        .trig_origin(trig_origin), .trig_style(trig_style));

    tme_host u_tme_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ***************************************
    // Compare and report
    // ***************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic feat(input logic [11:0] a, input logic pix, input logic [11:0] v,
                        input int pos, input logic bad);
        pixel_16bit <= pix;
        u_tme_host.wr(a, {20'hABCDE, v});
        u_tme_host.rd(OFS_ERR_HIGH, rv);
        chk(rv, 32'(bad) << pos);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    // ***************************************
    // Test sequence
    // ***************************************
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk({24'h0, trig_polarity, trig_origin, trig_style}, 32'h0000_0081);
        u_tme_host.rd(OFS_TRIG_CTRL, rv);
        chk(rv, 32'h8301_0000);
        u_tme_host.rd(OFS_ERR_HIGH, rv);
        chk(rv, 32'h0000_0000);
        $display("test reset done");
        feat(OFS_BRIGHT_DEF, 1'b0, 12'h400, POS_ERR_BRIGHT, 1'b1);
        feat(OFS_BRIGHT_DEF, 1'b0, 12'h3FF, POS_ERR_BRIGHT, 1'b0);
        feat(OFS_SHUTTER_DEF, 1'b0, 12'h000, POS_ERR_SHUTTER, 1'b1);
        feat(OFS_SHUTTER_DEF, 1'b0, 12'hFFF, POS_ERR_SHUTTER, 1'b0);
        feat(OFS_SHUTTER_DEF, 1'b0, 12'h001, POS_ERR_SHUTTER, 1'b0);
        feat(OFS_GAIN, 1'b0, 12'h2E5, POS_ERR_GAIN, 1'b1);
        feat(OFS_GAIN, 1'b0, 12'h2E4, POS_ERR_GAIN, 1'b0);
        feat(OFS_GAIN, 1'b1, 12'h07E, POS_ERR_GAIN, 1'b1);
        feat(OFS_GAIN, 1'b1, 12'h07D, POS_ERR_GAIN, 1'b0);
        $display("test feature flags done");
        for (int o = 0; o < 8; o++)
        begin
            for (int s = 0; s < 3; s++)
            begin
                pol = o[0];
                err = (o > 3 && o != 7) || s > 1 || (o == 7 && s == 1);
                u_tme_host.wr(OFS_TRIG_CTRL, {6'h10, 1'b0, pol, o[2:0], 1'b1, s[3:0],
                    16'h0ABC});
                u_tme_host.rd(OFS_ERR_HIGH, rv);
                chk(rv, 32'(err) << POS_ERR_TRIG);
                u_tme_host.rd(OFS_TRIG_CTRL, rv);
                chk(rv, {6'h20, 1'b1, pol, o[2:0], 1'b0, s[3:0], 16'h0000});
                chk({24'h0, trig_polarity, trig_origin, trig_style},
                    {24'h0, pol, o[2:0], s[3:0]});
            end
        end
        $display("test trigger codes done");
        ce <= 1'b0;
        u_tme_host.wr(OFS_TRIG_CTRL, 32'h0000_0000);
        ce <= 1'b1;
        u_tme_host.rd(OFS_TRIG_CTRL, rv);
        chk(rv, 32'h83E2_0000);
        u_tme_host.wr(OFS_TRIG_CTRL, 32'h00E0_0000);
        u_tme_host.wr(OFS_ERR_HIGH, 32'hFFFF_FFFF);
        u_tme_host.rd(OFS_ERR_HIGH, rv);
        chk(rv, 32'h0000_0000);
        u_tme_host.rd(12'h844, rv);
        chk(rv, 32'h0000_0000);
        $display("test refusals done");
        conclude();
    end
endmodule
